// >>> hdl/swf_status_word.sv
// Program status word: arithmetic flags, user flags, bank select and parity
//
// What this block does
// - Carry set on carry or borrow, else cleared
// - Half carry from low nibble, else cleared
// - Overflow on signed overflow of add/subtract
// - Overflow when product exceeds one byte
// - Overflow on divide by zero
// - These instructions otherwise clear overflow
// - Status word at 0xD0, bit-addressable, any page
`timescale 1ns/10ps
module swf_status_word (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input swf_pkg::swf_alu_req_t alu_req,
  input swf_pkg::swf_sfr_req_t sfr_req,
  input swf_pkg::swf_bit_req_t bit_req,
  input wire logic [7:0] acc,
  output logic [15:0] alu_result,
  output logic alu_done,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  output logic bit_rdata,
  output logic bit_rvalid,
  output logic [7:0] status_word,
  output logic [1:0] bank_select,
  output logic [7:0] bank_base
);
  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic bit_hit(input logic [7:0] addr, input int unsigned pos);
    bit_hit = addr == (swf_pkg::SWF_BIT_BASE + 8'(pos));
  endfunction : bit_hit

  logic [7:0] psw_reg;
  logic [7:0] psw_next;
  logic [1:0] carry_half_reg;
  logic over_reg;
  logic [1:0] user_reg;
  logic [1:0] bank_reg;
  logic parity_reg;
  logic [15:0] result_reg;
  logic done_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic brdata_reg;
  logic brvalid_reg;
  logic byte_wr;
  logic alu_fire;
  swf_pkg::swf_alu_out_t alu_out;

  assign byte_wr = sfr_req.wr && (sfr_req.addr == swf_pkg::SWF_PSW_ADDR);
  assign alu_fire = alu_req.valid && (alu_req.op != swf_pkg::SWF_NO_OP);

  swf_arith u_arith (
    .op(alu_req.op),
    .a(alu_req.a),
    .b(alu_req.b),
    .cin(psw_reg[swf_pkg::SWF_CARRY_POS]),
    .res(alu_out)
  );

  // ****************************************************************
  // Next status word
  // ****************************************************************
  always_comb begin
    psw_next = psw_reg;
    if (byte_wr) begin
      psw_next[7:1] = sfr_req.wdata[7:1];
    end
    for (int unsigned i = 1; i < 8; i++) begin
      if (bit_req.wr && bit_hit(bit_req.addr, i)) begin
        psw_next[i] = bit_req.val;
      end
    end
    // Hardware flag updates win over a software write in the same cycle
    if (alu_fire) begin
      psw_next[swf_pkg::SWF_CARRY_POS] = alu_out.carry;
      psw_next[swf_pkg::SWF_HALF_POS] = alu_out.half;
      psw_next[swf_pkg::SWF_OVER_POS] = alu_out.over;
    end
    psw_next[swf_pkg::SWF_PARITY_POS] = ^acc;
  end

  // ****************************************************************
  // Arithmetic flags
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      carry_half_reg <= swf_pkg::SWF_PSW_RESET[7:6];
      over_reg <= swf_pkg::SWF_PSW_RESET[2];
    end else if (clk_en) begin
      carry_half_reg <= psw_next[7:6];
      over_reg <= psw_next[2];
    end
  end

  // ****************************************************************
  // User flags and bank select
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      user_reg <= {swf_pkg::SWF_PSW_RESET[5], swf_pkg::SWF_PSW_RESET[1]};
    end else if (clk_en) begin
      user_reg <= {psw_next[5], psw_next[1]};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bank_reg <= swf_pkg::SWF_BANK_RESET;
    end else if (clk_en) begin
      bank_reg <= psw_next[4:3];
    end
  end

  // ****************************************************************
  // Parity
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      parity_reg <= swf_pkg::SWF_PSW_RESET[0];
    end else if (clk_en) begin
      parity_reg <= psw_next[0];
    end
  end

  // ****************************************************************
  // Arithmetic result
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      result_reg <= swf_pkg::SWF_RESULT_RESET;
      done_reg <= 1'b0;
    end else if (clk_en) begin
      done_reg <= alu_fire;
      if (alu_fire) begin
        result_reg <= alu_out.result;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_reg <= swf_pkg::SWF_READ_IDLE;
      rvalid_reg <= 1'b0;
      brdata_reg <= 1'b0;
      brvalid_reg <= 1'b0;
    end else if (clk_en) begin
      rvalid_reg <= sfr_req.rd && (sfr_req.addr == swf_pkg::SWF_PSW_ADDR);
      rdata_reg <= (sfr_req.rd && (sfr_req.addr == swf_pkg::SWF_PSW_ADDR)) ?
                   psw_reg : swf_pkg::SWF_READ_IDLE;
      brvalid_reg <= bit_req.rd && (bit_req.addr[7:3] == swf_pkg::SWF_BIT_BASE[7:3]);
      brdata_reg <= bit_req.rd && (bit_req.addr[7:3] == swf_pkg::SWF_BIT_BASE[7:3]) &&
                    psw_reg[bit_req.addr[2:0]];
    end
  end

  assign alu_result = result_reg;
  assign alu_done = done_reg;
  assign sfr_rdata = rdata_reg;
  assign sfr_rvalid = rvalid_reg;
  assign bit_rdata = brdata_reg;
  assign bit_rvalid = brvalid_reg;
  // Word assembled from the per-concern registers, one driver per bit
  assign psw_reg = {carry_half_reg, user_reg[1], bank_reg, over_reg, user_reg[0], parity_reg};
  assign status_word = psw_reg;
  assign bank_select = psw_reg[4:3];
  assign bank_base = {3'h0, psw_reg[4:3], 3'h0};

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic chk_fire;
  swf_pkg::swf_op_t chk_op;
  logic [7:0] chk_a;
  logic [7:0] chk_b;
  logic chk_cin;
  logic [8:0] chk_sum;
  logic [8:0] chk_dif;
  logic [15:0] chk_prod;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      chk_fire <= 1'b0;
      chk_op <= swf_pkg::SWF_NO_OP;
      chk_a <= 8'h00;
      chk_b <= 8'h00;
      chk_cin <= 1'b0;
    end else if (clk_en) begin
      chk_fire <= alu_fire;
      chk_op <= alu_req.op;
      chk_a <= alu_req.a;
      chk_b <= alu_req.b;
      chk_cin <= psw_reg[7];
    end
  end

  assign chk_sum = {1'b0, chk_a} + {1'b0, chk_b};
  assign chk_dif = {1'b0, chk_a} - {1'b0, chk_b} - 9'(chk_cin);
  assign chk_prod = 16'(chk_a) * 16'(chk_b);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_carry;
    chk_fire && (chk_op == swf_pkg::SWF_ADD_OP) |-> psw_reg[7] == chk_sum[8];
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong after add");

  property p_borrow;
    chk_fire && (chk_op == swf_pkg::SWF_SUBTRACT_BORROW_OP) |-> psw_reg[7] == chk_dif[8];
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow wrong after subtract");

  property p_half;
    chk_fire && (chk_op == swf_pkg::SWF_ADD_OP)
      |-> psw_reg[6] == ((5'(chk_a[3:0]) + 5'(chk_b[3:0])) > 5'h0F);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong after add");

  property p_user_hold;
    clk_en && !sfr_req.wr && !bit_req.wr |=> $stable(psw_reg[5]) && $stable(psw_reg[1]);
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("user flag moved");

  property p_bank;
    bank_base == {3'h0, bank_select, 3'h0} && bank_select == status_word[4:3];
  endproperty
  a_bank: assert property (p_bank) else $error("bank base mismatch");

  property p_signed_ovf;
    chk_fire && (chk_op == swf_pkg::SWF_ADD_OP)
      |-> psw_reg[2] == ((chk_a[7] == chk_b[7]) && (chk_sum[7] != chk_a[7]));
  endproperty
  a_signed_ovf: assert property (p_signed_ovf) else $error("signed overflow wrong");

  property p_mul_ovf;
    chk_fire && (chk_op == swf_pkg::SWF_MULTIPLY_OP)
      |-> psw_reg[2] == (chk_prod > 16'h00FF) && psw_reg[7] == 1'b0;
  endproperty
  a_mul_ovf: assert property (p_mul_ovf) else $error("multiply overflow wrong");

  property p_div_zero;
    chk_fire && (chk_op == swf_pkg::SWF_DIVIDE_OP) |-> psw_reg[2] == (chk_b == 8'h00);
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("divide overflow wrong");

  property p_byte_write;
    clk_en && byte_wr && !alu_fire && !bit_req.wr |=> psw_reg[7:1] == $past(sfr_req.wdata[7:1]);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write lost");

  property p_parity;
    clk_en |=> psw_reg[0] == ^$past(acc);
  endproperty
  a_parity: assert property (p_parity) else $error("parity mismatch");

  property p_reset;
    @(posedge clk_sys) disable iff (1'b0) reset |-> psw_reg[7:1] == 7'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("status not cleared");

  c_add_carry: cover property (chk_fire && (chk_op == swf_pkg::SWF_ADD_OP) && psw_reg[7]);
  c_mul_ovf: cover property (chk_fire && (chk_op == swf_pkg::SWF_MULTIPLY_OP) && psw_reg[2]);
  c_div_zero: cover property (chk_fire && (chk_op == swf_pkg::SWF_DIVIDE_OP) && psw_reg[2]);
  c_bank3: cover property (bank_select == 2'h3);
endmodule : swf_status_word

// >>> common/swf_pkg.sv
// Shared constants and carrier types for the status word flag block
package swf_pkg;
  // ****************************************************************
  // Addresses and field positions
  // ****************************************************************
  localparam logic [7:0] SWF_PSW_ADDR = 8'hD0;
  localparam logic [7:0] SWF_BIT_BASE = 8'hD0;
  localparam int unsigned SWF_CARRY_POS = 7;
  localparam int unsigned SWF_HALF_POS = 6;
  localparam int unsigned SWF_USER0_POS = 5;
  localparam int unsigned SWF_BANK_HI_POS = 4;
  localparam int unsigned SWF_BANK_LO_POS = 3;
  localparam int unsigned SWF_OVER_POS = 2;
  localparam int unsigned SWF_USER1_POS = 1;
  localparam int unsigned SWF_PARITY_POS = 0;
  localparam int unsigned SWF_BANK_SHIFT = 3;

  // ****************************************************************
  // Values after reset and limits
  // ****************************************************************
  localparam logic [7:0] SWF_PSW_RESET = 8'h00;
  localparam logic [1:0] SWF_BANK_RESET = 2'h0;
  localparam logic [15:0] SWF_RESULT_RESET = 16'h0000;
  localparam logic [15:0] SWF_BYTE_MAX = 16'h00FF;
  localparam logic [7:0] SWF_READ_IDLE = 8'h00;

  // ****************************************************************
  // Operations and carriers
  // ****************************************************************
  typedef enum logic [2:0] {
    SWF_NO_OP = 3'h0,
    SWF_ADD_OP = 3'h1,
    SWF_ADD_WITH_CARRY_OP = 3'h2,
    SWF_SUBTRACT_BORROW_OP = 3'h3,
    SWF_MULTIPLY_OP = 3'h4,
    SWF_DIVIDE_OP = 3'h5
  } swf_op_t;

  typedef struct packed {
    logic valid;
    swf_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } swf_alu_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } swf_sfr_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic val;
  } swf_bit_req_t;

  typedef struct packed {
    logic carry;
    logic half;
    logic over;
    logic [15:0] result;
  } swf_alu_out_t;
endpackage : swf_pkg

// >>> hdl/swf_arith.sv
// Arithmetic result and flag computation for the status word block
`timescale 1ns/10ps
module swf_arith (
  input swf_pkg::swf_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output swf_pkg::swf_alu_out_t res
);
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [15:0] prod;

  always_comb begin
    res = '0;
    sum9 = 9'h000;
    nib5 = 5'h00;
    prod = 16'(a) * 16'(b);
    unique case (op)
      swf_pkg::SWF_ADD_OP, swf_pkg::SWF_ADD_WITH_CARRY_OP: begin
        sum9 = {1'b0, a} + {1'b0, b} + 9'((op == swf_pkg::SWF_ADD_WITH_CARRY_OP) && cin);
        nib5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} +
               5'((op == swf_pkg::SWF_ADD_WITH_CARRY_OP) && cin);
        res.result = {8'h00, sum9[7:0]};
        res.carry = sum9[8];
        res.half = nib5[4];
        res.over = (a[7] == b[7]) && (sum9[7] != a[7]);
      end
      swf_pkg::SWF_SUBTRACT_BORROW_OP: begin
        sum9 = {1'b0, a} - {1'b0, b} - 9'(cin);
        nib5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(cin);
        res.result = {8'h00, sum9[7:0]};
        res.carry = sum9[8];
        res.half = nib5[4];
        res.over = (a[7] != b[7]) && (sum9[7] != a[7]);
      end
      swf_pkg::SWF_MULTIPLY_OP: begin
        res.result = prod;
        res.over = prod > swf_pkg::SWF_BYTE_MAX;
      end
      swf_pkg::SWF_DIVIDE_OP: begin
        if (b == 8'h00) begin
          res.over = 1'b1;
        end else begin
          res.result = {a % b, a / b};
        end
      end
      default: begin
        res = '0;
      end
    endcase
  end
endmodule : swf_arith

// >>> testbench/swf_status_word_test.sv
// Self-checking testbench for the status word flag block
`timescale 1ns/10ps
module swf_status_word_test;
  logic clk_sys, reset, clk_en;
  swf_pkg::swf_alu_req_t alu_req;
  swf_pkg::swf_sfr_req_t sfr_req;
  swf_pkg::swf_bit_req_t bit_req;
  logic [7:0] acc, sfr_rdata, status_word, bank_base, exp_psw;
  logic [15:0] alu_result;
  logic alu_done, sfr_rvalid, bit_rdata, bit_rvalid;
  logic [1:0] bank_select;
  int fails, checks_done;
  logic [18:0] corner [10] = '{19'h1FF01, 19'h17F01, 19'h20000, 19'h1FFFF, 19'h20101,
    19'h30001, 19'h38001, 19'h41010, 19'h40F11, 19'h51000};

  swf_status_word swf_status_word_inst (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .alu_req(alu_req), .sfr_req(sfr_req), .bit_req(bit_req), .acc(acc),
    .alu_result(alu_result), .alu_done(alu_done), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .bit_rdata(bit_rdata), .bit_rvalid(bit_rvalid),
    .status_word(status_word), .bank_select(bank_select), .bank_base(bank_base));

  // ****************************************************************
  // Clock, checking and closing
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    complete_run();
  end

  // ****************************************************************
  // Expected flags {carry, half, overflow, result}
  // ****************************************************************
  function automatic logic [18:0] model(swf_pkg::swf_op_t op, logic [7:0] a, logic [7:0] b,
                                        logic c);
    logic [8:0] s;
    logic [4:0] h;
    logic [15:0] p;
    logic ci;
    ci = (op == swf_pkg::SWF_ADD_OP) ? 1'b0 : c;
    p = {8'h00, a} * {8'h00, b};
    case (op)
      swf_pkg::SWF_ADD_OP, swf_pkg::SWF_ADD_WITH_CARRY_OP: begin
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {s[8], h[4], (a[7] == b[7]) && (s[7] != a[7]), 8'h00, s[7:0]};
      end
      swf_pkg::SWF_SUBTRACT_BORROW_OP: begin
        s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        return {s[8], h[4], (a[7] != b[7]) && (s[7] != a[7]), 8'h00, s[7:0]};
      end
      swf_pkg::SWF_MULTIPLY_OP: return {2'b00, p > 16'h00FF, p};
      default: return (b == 8'h00) ? 19'h10000 : {3'b000, a % b, a / b};
    endcase
  endfunction : model

  // ****************************************************************
  // Request tasks, each entered just after a rising edge
  // ****************************************************************
  task automatic run_op(input swf_pkg::swf_op_t op, input logic [7:0] a, input logic [7:0] b);
    logic [18:0] e;
    e = model(op, a, b, exp_psw[7]);
    alu_req = '{1'b1, op, a, b};
    acc = a;
    @(posedge clk_sys);
    #1;
    alu_req.valid = 1'b0;
    exp_psw = {e[18:17], exp_psw[5:3], e[16], exp_psw[1], ^a};
    check(alu_done, 16'h0001, "done");
    check(alu_result, e[15:0], "result");
    check(status_word[7], e[18], "carry");
    check(status_word[6], e[17], "half");
    check(status_word[2], e[16], "overflow");
    check(status_word, exp_psw, "word");
    @(posedge clk_sys);
    #1;
    check(alu_done, 16'h0000, "done pulse");
  endtask : run_op

  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    sfr_req = '{1'b1, 1'b0, addr, data};
    @(posedge clk_sys);
    #1;
    sfr_req.wr = 1'b0;
    if (addr == swf_pkg::SWF_PSW_ADDR)
      exp_psw[7:1] = data[7:1];
    check(status_word, {exp_psw[7:1], ^acc}, "byte write");
    @(posedge clk_sys);
    #1;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] addr);
    logic hit;
    hit = (addr == swf_pkg::SWF_PSW_ADDR);
    sfr_req = '{1'b0, 1'b1, addr, 8'h00};
    @(posedge clk_sys);
    #1;
    sfr_req.rd = 1'b0;
    check(sfr_rvalid, hit, "read valid");
    check(sfr_rdata, hit ? {exp_psw[7:1], ^acc} : 8'h00, "read data");
    @(posedge clk_sys);
    #1;
    check(sfr_rvalid, 16'h0000, "read valid pulse");
    check(sfr_rdata, 16'h0000, "read data idle");
  endtask : sfr_read

  task automatic bit_access(input int n, input logic v);
    bit_req = '{1'b1, 1'b0, swf_pkg::SWF_BIT_BASE + 8'(n), v};
    @(posedge clk_sys);
    #1;
    bit_req = '{1'b0, 1'b1, swf_pkg::SWF_BIT_BASE + 8'(n), 1'b0};
    if (n != 0)
      exp_psw[n] = v;
    @(posedge clk_sys);
    #1;
    bit_req.rd = 1'b0;
    check(bit_rvalid, 16'h0001, "bit valid");
    check(bit_rdata, (n == 0) ? ^acc : exp_psw[n], "bit data");
    @(posedge clk_sys);
    #1;
  endtask : bit_access

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    alu_req = '0;
    sfr_req = '0;
    bit_req = '0;
    acc = 8'h00;
    exp_psw = 8'h00;
    fails = 0;
    checks_done = 0;
    void'($urandom(60));
    repeat (6) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    check(status_word, 16'h0000, "reset word");
    check(bank_base, 16'h0000, "reset bank");
    foreach (corner[i])
      run_op(swf_pkg::swf_op_t'(corner[i][18:16]), corner[i][15:8], corner[i][7:0]);
    for (int k = 0; k < 4; k++) begin
      sfr_write(swf_pkg::SWF_PSW_ADDR, {3'($urandom), 2'(k), 3'($urandom)});
      check(bank_select, 16'(k), "bank");
      check(bank_base, 16'(k * 8), "bank base");
    end
    sfr_read(swf_pkg::SWF_PSW_ADDR);
    sfr_read(8'hD1);
    sfr_write(8'hD1, 8'hFF);
    for (int n = 0; n < 8; n++)
      bit_access(n, ~exp_psw[n]);
    clk_en = 1'b0;
    alu_req = '{1'b1, swf_pkg::SWF_ADD_OP, 8'hFF, 8'hFF};
    @(posedge clk_sys);
    #1;
    check(alu_done, 16'h0000, "frozen done");
    check(status_word, {exp_psw[7:1], ^acc}, "frozen word");
    alu_req.valid = 1'b0;
    clk_en = 1'b1;
    @(posedge clk_sys);
    #1;
    repeat (80) begin
      if ($urandom_range(3) == 0)
        bit_access(int'($urandom_range(7)), 1'($urandom));
      run_op(swf_pkg::swf_op_t'(3'($urandom_range(5, 1))), 8'($urandom), 8'($urandom));
    end
    reset = 1'b1;
    #2;
    check(status_word, 16'h0000, "second reset");
    check(bank_select, 16'h0000, "second reset bank");
    exp_psw = 8'h00;
    @(posedge clk_sys);
    #1;
    reset = 1'b0;
    run_op(swf_pkg::SWF_ADD_WITH_CARRY_OP, 8'h0F, 8'h01);
    complete_run();
  end
endmodule : swf_status_word_test
